// ===== verilog/crsel_pkg.sv
package crsel_pkg;
  // register addresses
  localparam logic [7:0] CRSEL_ADDR_SELECT = 8'hff;
  localparam logic [7:0] CRSEL_ADDR_CH_RESET = 8'h00;
  localparam logic [7:0] CRSEL_ADDR_CH_STATUS = 8'h01;
  // select register fields
  localparam int CRSEL_SEL_BCAST_BIT = 3;
  localparam int CRSEL_SEL_EN_BIT = 2;
  localparam int CRSEL_SEL_CH_MSB = 1;
  localparam int CRSEL_SEL_CH_LSB = 0;
  localparam logic [7:0] CRSEL_SEL_RESET = 8'h00;
  // channel reset control fields
  localparam int CRSEL_CTL_CORE_BIT = 3;
  localparam int CRSEL_CTL_REGS_BIT = 2;
  localparam int CRSEL_CTL_REF_BIT = 1;
  localparam int CRSEL_CTL_OSC_BIT = 0;
  localparam logic [7:0] CRSEL_CTL_RESET = 8'h00;
  // channel status fields
  localparam int CRSEL_ST_RW_LSB = 5;
  localparam logic [2:0] CRSEL_ST_RW_RESET = 3'h0;
  localparam int CRSEL_ST_LOCK_BIT = 4;
  localparam int CRSEL_ST_SIG_BIT = 0;
  // value returned for the unreadable select register and unmapped channel addresses
  localparam logic [7:0] CRSEL_UNDEF_READ = 8'h00;
  localparam int CRSEL_NUM_CH = 4;

  // one register access from the bus protocol engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crsel_acc_s;

  // per-channel reset levels
  typedef struct packed {
    logic core_rst;
    logic refclock_domain_reset;
    logic osc_divider_domain_reset;
  } crsel_chctl_s;

  // a write reaches channel idx when broadcasting or when idx is the target
  function automatic logic crsel_wr_hit(input logic [7:0] sel, input logic [1:0] idx);
    crsel_wr_hit = sel[CRSEL_SEL_BCAST_BIT] || (sel[CRSEL_SEL_CH_MSB:CRSEL_SEL_CH_LSB] == idx);
  endfunction
endpackage

// ===== verilog/crsel_chan.sv
`timescale 1ns/1ps
module crsel_chan
  import crsel_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic cdr_lock_pin,
  input wire logic sig_det_pin,
  output crsel_chctl_s ctl
);
  logic [7:0] ctl_q, ctl_d;
  logic [2:0] st_rw_q, st_rw_d;
  logic lock_lost_q, lock_lost_d, sig_lost_q, sig_lost_d;
  logic [2:0] lock_sync_q, sig_sync_q;

  // address decode
  wire hit_ctl = addr == CRSEL_ADDR_CH_RESET;
  wire hit_st = addr == CRSEL_ADDR_CH_STATUS;
  wire regs_rst = rst || ctl_q[CRSEL_CTL_REGS_BIT];
  wire lock_fall = lock_sync_q[2] && !lock_sync_q[1];
  wire sig_fall = sig_sync_q[2] && !sig_sync_q[1];
  wire st_read = rd_en && hit_st;

  // next state; read-only status bits ignore writes, set wins over clear-on-read
  assign ctl_d = (wr_en && hit_ctl) ? wdata : ctl_q;
  assign st_rw_d = (wr_en && hit_st) ? wdata[7:CRSEL_ST_RW_LSB] : st_rw_q;
  assign lock_lost_d = lock_fall || (lock_lost_q && !st_read);
  assign sig_lost_d = sig_fall || (sig_lost_q && !st_read);

  // read data of this channel set
  assign rdata = hit_ctl ? ctl_q :
                 hit_st ? {st_rw_q, lock_lost_q, 3'h0, sig_lost_q} : CRSEL_UNDEF_READ;

  // reset levels toward this channel only
  assign ctl.core_rst = ctl_q[CRSEL_CTL_CORE_BIT];
  assign ctl.refclock_domain_reset = ctl_q[CRSEL_CTL_REF_BIT];
  assign ctl.osc_divider_domain_reset = ctl_q[CRSEL_CTL_OSC_BIT];

  // status pin synchronisers, stage 0 read only by stage 1
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_sync_q <= 3'h0;
      sig_sync_q <= 3'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[1:0], cdr_lock_pin};
      sig_sync_q <= {sig_sync_q[1:0], sig_det_pin};
    end
  end

  // channel register set, restored to defaults by its own reset bit
  always_ff @(posedge ref_clk) begin
    if (regs_rst) begin
      ctl_q <= CRSEL_CTL_RESET;
      st_rw_q <= CRSEL_ST_RW_RESET;
      lock_lost_q <= 1'b0;
      sig_lost_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      st_rw_q <= st_rw_d;
      lock_lost_q <= lock_lost_d;
      sig_lost_q <= sig_lost_d;
    end
  end

  // lost lock raises the flag at the next edge
  property p_lock_flag_set;
    @(posedge ref_clk) disable iff (regs_rst) lock_fall |=> lock_lost_q;
  endproperty
  a_lock_flag_set: assert property (p_lock_flag_set) else $error("lock loss flag not set");

  // self reset returns the control register to default and clears the lock flag
  property p_regs_reset;
    @(posedge ref_clk) disable iff (rst) ctl_q[CRSEL_CTL_REGS_BIT] |=> (ctl_q == CRSEL_CTL_RESET) && !lock_lost_q;
  endproperty
  a_regs_reset: assert property (p_regs_reset) else $error("channel registers not restored");

  // lost input signal raises its flag at the next edge
  property p_sig_flag_set;
    @(posedge ref_clk) disable iff (regs_rst) sig_fall |=> sig_lost_q;
  endproperty
  a_sig_flag_set: assert property (p_sig_flag_set) else $error("signal loss flag not set");

  // status read clears the lock flag unless a new loss arrives
  property p_lock_flag_clear;
    @(posedge ref_clk) disable iff (rst) st_read && !lock_fall |=> !lock_lost_q;
  endproperty
  a_lock_flag_clear: assert property (p_lock_flag_clear) else $error("lock loss flag not cleared");

  // status writes leave the read-only flags alone
  sequence s_st_write_quiet;
    wr_en && hit_st && !lock_fall && !sig_fall && !st_read;
  endsequence
  property p_status_ro;
    @(posedge ref_clk) disable iff (regs_rst)
      s_st_write_quiet |=> (lock_lost_q == $past(lock_lost_q)) && (sig_lost_q == $past(sig_lost_q));
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("read-only flag written");
endmodule

// ===== verilog/crsel_top.sv
`timescale 1ns/1ps
// Operation
// - broadcast bit writes all four channel sets
// - reads come only from the target channel
// - enable clear sends accesses to shared set
// - enabled access hits selected channel's register
// - writes to select address always update it
// - select register reads return undefined value
// - select values map shared, channel, broadcast
// - selection persists until rewritten by host
// - four independent complete channel register sets
// - control bit three holds core in reset
// - control bit two restores channel register defaults
// - bits one, zero reset clock domains
// - status bit four flags lock loss, clears-on-read
// - status bit zero flags lost input signal
// - writes to read-only bits are ignored
module crsel_top
  import crsel_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input crsel_acc_s acc,
  input wire logic [7:0] shared_rdata,
  input wire logic [3:0] cdr_lock_pin,
  input wire logic [3:0] sig_det_pin,
  output logic shared_wr,
  output logic shared_rd,
  output logic [7:0] rdata_q,
  output logic rd_valid_q,
  output crsel_chctl_s [3:0] chan_ctl
);
  logic [7:0] sel_q, sel_d;
  logic [7:0] rdata_d;
  logic [3:0] ch_wr, ch_rd;
  logic [7:0] ch_rdata [CRSEL_NUM_CH];
  logic [3:0] core_vec;
  logic [3:0] ref_vec, osc_vec;

  // selection decode
  wire is_sel_addr = acc.addr == CRSEL_ADDR_SELECT;
  wire chan_en = sel_q[CRSEL_SEL_EN_BIT];
  wire bcast = sel_q[CRSEL_SEL_BCAST_BIT];
  wire [1:0] tgt = sel_q[CRSEL_SEL_CH_MSB:CRSEL_SEL_CH_LSB];
  wire chan_path = chan_en && !is_sel_addr;

  // shared set strobes; the select register itself lives here
  assign shared_wr = acc.wr && !chan_path && !is_sel_addr;
  assign shared_rd = acc.rd && !chan_path && !is_sel_addr;

  // select register takes every write to its address
  assign sel_d = (acc.wr && is_sel_addr) ? acc.wdata : sel_q;

  // read mux: select address undefined, else target channel or shared set
  assign rdata_d = is_sel_addr ? CRSEL_UNDEF_READ :
                   chan_en ? ch_rdata[tgt] : shared_rdata;

  // four channel register sets
  for (genvar i = 0; i < CRSEL_NUM_CH; i++) begin : g_ch
    assign ch_wr[i] = acc.wr && chan_path && crsel_wr_hit(sel_q, 2'(i));
    assign ch_rd[i] = acc.rd && chan_path && (tgt == 2'(i));
    assign core_vec[i] = chan_ctl[i].core_rst;
    assign ref_vec[i] = chan_ctl[i].refclock_domain_reset;
    assign osc_vec[i] = chan_ctl[i].osc_divider_domain_reset;
    crsel_chan u_chan (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(ch_wr[i]),
      .rd_en(ch_rd[i]),
      .addr(acc.addr),
      .wdata(acc.wdata),
      .rdata(ch_rdata[i]),
      .cdr_lock_pin(cdr_lock_pin[i]),
      .sig_det_pin(sig_det_pin[i]),
      .ctl(chan_ctl[i])
    );
  end

  // select register and registered read answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_q <= CRSEL_SEL_RESET;
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      if (acc.rd) begin
        rdata_q <= rdata_d;
      end
      rd_valid_q <= acc.rd;
    end
  end

  // helpers for the checks below
  wire tgt_core = core_vec[tgt];
  wire wd_core = acc.wdata[CRSEL_CTL_CORE_BIT];
  wire ctl_wr = acc.wr && acc.addr == CRSEL_ADDR_CH_RESET;
  wire ctl_rd = acc.rd && acc.addr == CRSEL_ADDR_CH_RESET;
  wire wd_ref = acc.wdata[CRSEL_CTL_REF_BIT];
  wire wd_osc = acc.wdata[CRSEL_CTL_OSC_BIT];
  wire any_acc = acc.wr || acc.rd;
  wire tgt_ref = ref_vec[tgt];
  wire tgt_osc = osc_vec[tgt];
  wire [7:0] tgt_rdata = ch_rdata[tgt];
  wire [3:0] tgt_onehot = 4'h1 << tgt;
  wire [3:0] sel_code = sel_q[CRSEL_SEL_BCAST_BIT:CRSEL_SEL_CH_LSB];
  wire unmapped = !is_sel_addr && acc.addr != CRSEL_ADDR_CH_RESET && acc.addr != CRSEL_ADDR_CH_STATUS;

  // broadcast write lands in all four channels
  sequence s_bcast_ctl_wr;
    ctl_wr && chan_en && bcast;
  endsequence
  property p_bcast_all;
    @(posedge ref_clk) disable iff (rst) s_bcast_ctl_wr |=> (core_vec == {4{$past(wd_core)}});
  endproperty
  a_bcast_all: assert property (p_bcast_all) else $error("broadcast write missed a channel");

  // read answers from target channel even when broadcasting
  property p_read_target;
    @(posedge ref_clk) disable iff (rst)
      ctl_rd && chan_en |=> rd_valid_q && (rdata_q[CRSEL_CTL_CORE_BIT] == $past(tgt_core));
  endproperty
  a_read_target: assert property (p_read_target) else $error("read not from target channel");

  // disabled selection goes to the shared set only
  property p_shared_off;
    @(posedge ref_clk) disable iff (rst)
      (acc.wr || acc.rd) && !chan_en && !is_sel_addr |-> (shared_wr || shared_rd) && (ch_wr == 4'h0) && (ch_rd == 4'h0);
  endproperty
  a_shared_off: assert property (p_shared_off) else $error("access escaped shared set");

  // single-channel write reaches only the target
  property p_chan_hit;
    @(posedge ref_clk) disable iff (rst)
      acc.wr && chan_en && !bcast && !is_sel_addr |-> (ch_wr == (4'h1 << tgt)) && !shared_wr;
  endproperty
  a_chan_hit: assert property (p_chan_hit) else $error("channel write misrouted");

  // select write always stored
  property p_sel_write;
    @(posedge ref_clk) disable iff (rst) acc.wr && is_sel_addr |=> sel_q == $past(acc.wdata);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select register not updated");

  // select register unreadable
  property p_sel_unread;
    @(posedge ref_clk) disable iff (rst) acc.rd && is_sel_addr |=> rdata_q == CRSEL_UNDEF_READ;
  endproperty
  a_sel_unread: assert property (p_sel_unread) else $error("select register read back");

  // selection holds between select writes
  property p_sel_hold;
    @(posedge ref_clk) disable iff (rst) !(acc.wr && is_sel_addr) |=> $stable(sel_q);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed without write");

  // core reset of target follows a single-channel control write
  sequence s_single_ctl_wr;
    ctl_wr && chan_en && !bcast;
  endsequence
  property p_core_follow;
    @(posedge ref_clk) disable iff (rst) s_single_ctl_wr |=> tgt_core == $past(wd_core);
  endproperty
  a_core_follow: assert property (p_core_follow) else $error("core reset not applied");

  // read answer valid exactly one cycle after each read
  property p_rd_valid;
    @(posedge ref_clk) disable iff (rst) 1'b1 |=> rd_valid_q == $past(acc.rd);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid timing wrong");

  // read answer holds until the next read
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (rst) !acc.rd |=> $stable(rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read answer changed without read");

  // shared read answer carries shared data
  property p_shared_data;
    @(posedge ref_clk) disable iff (rst)
      acc.rd && !chan_en && !is_sel_addr |=> rdata_q == $past(shared_rdata);
  endproperty
  a_shared_data: assert property (p_shared_data) else $error("shared read data lost");

  // channel read answer carries target channel data
  property p_chan_data;
    @(posedge ref_clk) disable iff (rst)
      acc.rd && chan_en && !is_sel_addr |=> rdata_q == $past(tgt_rdata);
  endproperty
  a_chan_data: assert property (p_chan_data) else $error("channel read data lost");

  // channel read strobes the target set only
  property p_chan_rd_one;
    @(posedge ref_clk) disable iff (rst)
      acc.rd && chan_en && !is_sel_addr |-> (ch_rd == tgt_onehot) && !shared_rd;
  endproperty
  a_chan_rd_one: assert property (p_chan_rd_one) else $error("channel read misrouted");

  // broadcast read still strobes one channel
  property p_bcast_rd_one;
    @(posedge ref_clk) disable iff (rst) acc.rd && chan_en && bcast && !is_sel_addr |-> (ch_rd == tgt_onehot);
  endproperty
  a_bcast_rd_one: assert property (p_bcast_rd_one) else $error("broadcast read hit several channels");

  // broadcast write strobes every channel set
  property p_bcast_strobe;
    @(posedge ref_clk) disable iff (rst)
      acc.wr && chan_en && bcast && !is_sel_addr |-> (ch_wr == 4'hf) && !shared_wr;
  endproperty
  a_bcast_strobe: assert property (p_bcast_strobe) else $error("broadcast strobe missed a channel");

  // select address never strobes a register set
  property p_sel_no_strobe;
    @(posedge ref_clk) disable iff (rst)
      any_acc && is_sel_addr |-> !shared_wr && !shared_rd && (ch_wr == 4'h0) && (ch_rd == 4'h0);
  endproperty
  a_sel_no_strobe: assert property (p_sel_no_strobe) else $error("select access strobed a set");

  // select read leaves the selection alone
  property p_sel_read_keep;
    @(posedge ref_clk) disable iff (rst) acc.rd && is_sel_addr |=> sel_q == $past(sel_q);
  endproperty
  a_sel_read_keep: assert property (p_sel_read_keep) else $error("select read disturbed selection");

  // no write strobe without a write request
  property p_no_wr_strobe;
    @(posedge ref_clk) disable iff (rst) !acc.wr |-> !shared_wr && (ch_wr == 4'h0);
  endproperty
  a_no_wr_strobe: assert property (p_no_wr_strobe) else $error("write strobe without request");

  // no read strobe without a read request
  property p_no_rd_strobe;
    @(posedge ref_clk) disable iff (rst) !acc.rd |-> !shared_rd && (ch_rd == 4'h0);
  endproperty
  a_no_rd_strobe: assert property (p_no_rd_strobe) else $error("read strobe without request");

  // shared strobes only with channel access off
  property p_shared_only_off;
    @(posedge ref_clk) disable iff (rst) (shared_wr || shared_rd) |-> !chan_en && !is_sel_addr;
  endproperty
  a_shared_only_off: assert property (p_shared_only_off) else $error("shared strobe while channels on");

  // reset returns to the shared set with all channel levels low
  property p_reset_state;
    @(posedge ref_clk) rst |=> (sel_q == CRSEL_SEL_RESET) && !rd_valid_q && (rdata_q == 8'h00)
      && (core_vec == 4'h0) && (ref_vec == 4'h0) && (osc_vec == 4'h0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  // select value zero steers everything to the shared set
  sequence s_shared_acc;
    any_acc && !is_sel_addr && (sel_code == 4'h0);
  endsequence
  property p_map_shared;
    @(posedge ref_clk) disable iff (rst)
      s_shared_acc |-> (shared_wr == acc.wr) && (shared_rd == acc.rd) && (ch_wr == 4'h0) && (ch_rd == 4'h0);
  endproperty
  a_map_shared: assert property (p_map_shared) else $error("value zero not shared");

  // values four to seven steer to one channel
  sequence s_single_acc;
    any_acc && !is_sel_addr && (sel_code >= 4'h4) && (sel_code <= 4'h7);
  endsequence
  property p_map_single;
    @(posedge ref_clk) disable iff (rst)
      s_single_acc |-> (ch_wr == (acc.wr ? tgt_onehot : 4'h0)) && (ch_rd == (acc.rd ? tgt_onehot : 4'h0));
  endproperty
  a_map_single: assert property (p_map_single) else $error("single channel value misrouted");

  // values twelve to fifteen write all, read one
  sequence s_bcast_acc;
    any_acc && !is_sel_addr && (sel_code >= 4'hc);
  endsequence
  property p_map_bcast;
    @(posedge ref_clk) disable iff (rst)
      s_bcast_acc |-> (ch_wr == {4{acc.wr}}) && (ch_rd == (acc.rd ? tgt_onehot : 4'h0))
        && !shared_wr && !shared_rd;
  endproperty
  a_map_bcast: assert property (p_map_bcast) else $error("broadcast value misrouted");

  // domain resets of target follow a single-channel write
  property p_domain_follow;
    @(posedge ref_clk) disable iff (rst)
      s_single_ctl_wr |=> (tgt_ref == $past(wd_ref)) && (tgt_osc == $past(wd_osc));
  endproperty
  a_domain_follow: assert property (p_domain_follow) else $error("domain resets not applied");

  // other channels keep their levels on a single-channel write
  property p_others_keep;
    @(posedge ref_clk) disable iff (rst)
      s_single_ctl_wr |=> ((core_vec ^ $past(core_vec)) & ~$past(tgt_onehot)) == 4'h0
        && ((ref_vec ^ $past(ref_vec)) & ~$past(tgt_onehot)) == 4'h0
        && ((osc_vec ^ $past(osc_vec)) & ~$past(tgt_onehot)) == 4'h0;
  endproperty
  a_others_keep: assert property (p_others_keep) else $error("write leaked into another channel");

  // broadcast write sets both domain resets in all channels
  property p_bcast_domains;
    @(posedge ref_clk) disable iff (rst)
      s_bcast_ctl_wr |=> (ref_vec == {4{$past(wd_ref)}}) && (osc_vec == {4{$past(wd_osc)}});
  endproperty
  a_bcast_domains: assert property (p_bcast_domains) else $error("broadcast reset levels differ");

  // unmapped channel addresses read the undefined value
  property p_chan_unmapped;
    @(posedge ref_clk) disable iff (rst) acc.rd && chan_en && unmapped |=> rdata_q == CRSEL_UNDEF_READ;
  endproperty
  a_chan_unmapped: assert property (p_chan_unmapped) else $error("unmapped channel address read back");
endmodule

// ===== testbench/crsel_host.sv
`timescale 1ns/1ps
module crsel_host
  import crsel_pkg::*;
(
  input wire logic ref_clk,
  input wire logic shared_wr,
  input wire logic shared_rd,
  input wire logic [7:0] rdata_q,
  input wire logic rd_valid_q,
  output crsel_acc_s acc
);
  initial acc = '0;
  // one write strobe; sh tells whether the shared set was hit
  task automatic write(input logic [7:0] a, input logic [7:0] d, output logic sh);
    @(posedge ref_clk);
    #1 acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    #1 sh = shared_wr;
    @(posedge ref_clk);
    #1 acc.wr = 1'b0;
  endtask
  // one read strobe; answer taken one edge later
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic sh, output logic vld);
    @(posedge ref_clk);
    #1 acc = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    #1 sh = shared_rd;
    @(posedge ref_clk);
    #1 acc.rd = 1'b0;
    vld = rd_valid_q;
    d = rdata_q;
  endtask
  // whole byte with upper nibble zero
  task automatic select(input logic [3:0] v, output logic sh);
    write(8'hff, {4'h0, v}, sh);
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import crsel_pkg::*;
  logic ref_clk, rst, shared_wr, shared_rd, rd_valid_q, sh, vld;
  crsel_acc_s acc;
  logic [7:0] shared_rdata, rdata_q, d, b;
  logic [3:0] cdr_lock_pin, sig_det_pin;
  crsel_chctl_s [3:0] chan_ctl;
  logic [7:0] v [4];
  int miscompares, checked, cycles;
  crsel_top u_crsel_top(.ref_clk(ref_clk), .rst(rst), .acc(acc), .shared_rdata(shared_rdata),
    .cdr_lock_pin(cdr_lock_pin), .sig_det_pin(sig_det_pin), .shared_wr(shared_wr), .shared_rd(shared_rd),
    .rdata_q(rdata_q), .rd_valid_q(rd_valid_q), .chan_ctl(chan_ctl));
  crsel_host u_crsel_host(.ref_clk(ref_clk), .shared_wr(shared_wr), .shared_rd(shared_rd),
    .rdata_q(rdata_q), .rd_valid_q(rd_valid_q), .acc(acc));
  // expected reset levels from a control byte
  function automatic crsel_chctl_s ctl_of(input logic [7:0] r);
    return '{core_rst: r[3], refclock_domain_reset: r[1], osc_divider_domain_reset: r[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_crsel_host.read(a, d, sh, vld);
    chk({7'h0, vld}, 8'h01);
    chk(d, exp);
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    shared_rdata = 8'h00;
    cdr_lock_pin = 4'h0;
    sig_det_pin = 4'h0;
    d = 8'($urandom(32'hd94dafbf));
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    // shared set after reset
    shared_rdata = 8'($urandom);
    rd_chk(8'h00, shared_rdata);
    chk({7'h0, sh}, 8'h01);
    u_crsel_host.write(8'h00, 8'h5a, sh);
    chk({7'h0, sh}, 8'h01);
    u_crsel_host.select(4'h4, sh);
    chk({7'h0, sh}, 8'h00);
    $display("test shared done");
    // distinct value into each channel
    for (int c = 0; c < 4; c++) begin
      u_crsel_host.select(4'h4 | 4'(c), sh);
      v[c] = 8'($urandom) & 8'hfb;
      u_crsel_host.write(8'h00, v[c], sh);
      chk({7'h0, sh}, 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      chk({5'h0, chan_ctl[c]}, {5'h0, ctl_of(v[c])});
      u_crsel_host.select(4'h4 | 4'(c), sh);
      rd_chk(8'h00, v[c]);
      chk({7'h0, sh}, 8'h00);
      u_crsel_host.select(4'hc | 4'(c), sh);
      rd_chk(8'h00, v[c]);
    end
    rd_chk(8'hff, CRSEL_UNDEF_READ);
    chk({7'h0, sh}, 8'h00);
    rd_chk(8'h05, CRSEL_UNDEF_READ);
    $display("test channels done");
    // broadcast write
    b = 8'($urandom) & 8'hfb;
    u_crsel_host.select(4'hc | 4'($urandom % 4), sh);
    u_crsel_host.write(8'h00, b, sh);
    for (int c = 0; c < 4; c++) begin
      chk({5'h0, chan_ctl[c]}, {5'h0, ctl_of(b)});
      u_crsel_host.select(4'h4 | 4'(c), sh);
      rd_chk(8'h00, b);
    end
    $display("test broadcast done");
    // broadcast bit without enable stays on the shared set
    u_crsel_host.select(4'h8, sh);
    u_crsel_host.write(8'h00, 8'h0b, sh);
    chk({7'h0, sh}, 8'h01);
    chk({5'h0, chan_ctl[0]}, {5'h0, ctl_of(b)});
    $display("test enable off done");
    // lock and signal acquired then lost on channel 2
    u_crsel_host.select(4'h6, sh);
    cdr_lock_pin[2] = 1'b1;
    sig_det_pin[2] = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 cdr_lock_pin[2] = 1'b0;
    sig_det_pin[2] = 1'b0;
    repeat (6) @(posedge ref_clk);
    rd_chk(8'h01, 8'h11);
    rd_chk(8'h01, 8'h00);
    u_crsel_host.write(8'h01, 8'hff, sh);
    rd_chk(8'h01, 8'he0);
    u_crsel_host.write(8'h00, 8'h0b, sh);
    u_crsel_host.write(8'h00, 8'h04, sh);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    chk({5'h0, chan_ctl[2]}, 8'h00);
    chk({5'h0, chan_ctl[1]}, {5'h0, ctl_of(b)});
    $display("test status done");
    // back to the shared set
    u_crsel_host.select(4'h0, sh);
    shared_rdata = 8'($urandom);
    rd_chk(8'h00, shared_rdata);
    $display("test return done");
    // reset in mid-run drops back to the shared set
    u_crsel_host.select(4'hc, sh);
    @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (int c = 0; c < 4; c++) begin
      chk({5'h0, chan_ctl[c]}, 8'h00);
    end
    shared_rdata = 8'($urandom);
    rd_chk(8'h00, shared_rdata);
    chk({7'h0, sh}, 8'h01);
    $display("test reset done");
    results();
  end
endmodule
